// File: src/lp_pkg.sv
package lp_pkg;

  // power states, gray coded along run -> grant -> sleep
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_GRANT = 2'b01,
    ST_SLEEP = 2'b11,
    ST_SMM   = 2'b10
  } pwr_state_t;

  // acknowledge transaction codes driven on the ack_code_out bus output
  localparam logic [1:0] ACK_NONE  = 2'h0;
  localparam logic [1:0] ACK_GRANT = 2'h1;
  localparam logic [1:0] ACK_SMI   = 2'h2;

  // unit clock-enable bit positions
  localparam int CLK_CORE  = 0;
  localparam int CLK_BUS   = 1;
  localparam int CLK_LIC   = 2;
  localparam int NUM_UNITS = 3;
  localparam logic [2:0] CLK_ALL  = 3'h7;
  localparam logic [2:0] CLK_NONE = 3'h0;
  localparam logic [2:0] CLK_KEEP = 3'h6;

  // bus outputs
  typedef struct packed {
    logic       valid;
    logic [1:0] code;
  } bus_ack_t;

  localparam int SYNC_STAGES = 2;
  localparam int IRQ_W       = 8;
  localparam logic [IRQ_W-1:0] IRQ_NONE = 8'h00;

endpackage

// File: src/sync2.sv
module sync2
  import lp_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rstn_in,
  input  wire logic d_in,
  output logic      q_out
);
  // first stage feeds only the second; idle value is deasserted (high)
  logic [SYNC_STAGES-1:0] sh_r;
  logic [SYNC_STAGES-1:0] sh_nxt;

  always_comb
  begin
    sh_nxt = {sh_r[SYNC_STAGES-2:0], d_in};
  end

  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
      sh_r <= {SYNC_STAGES{1'b1}};
    else
      sh_r <= sh_nxt;
  end

  assign q_out = sh_r[SYNC_STAGES-1];
endmodule // sync2

// File: src/low_power_state_and_smm_entry.sv
// Overview of operation
// - a synchronized stop-clock request while running, with no management interrupt in the same cycle, moves the block to stop-grant.
// - entering stop-grant from running issues one stop-grant acknowledge on the bus outputs.
// - in stop-grant only the bus and local interrupt controller clocks stay on.
// - in stop-grant snoops keep being answered and interrupts are latched as pending.
// - releasing stop-clock restarts all clocks, services pending interrupts and resumes.
// - stop-clock is synchronized internally and never touches the bus clock.
// - sleep request while in stop-grant, with stop-clock still asserted, moves the block into sleep.
// - in sleep every unit clock is stopped.
// - in sleep snoops and interrupts are ignored.
// - in sleep only the sleep and reset inputs are acted upon.
// - releasing sleep returns to stop-grant with bus and interrupt clocks restarted.
// - the management interrupt is synchronized before it is acted upon.
// - an accepted management interrupt saves the execution state and enters management mode.
// - after entering management mode an acknowledge is issued, then the handler starts.
// - with reset active all bus outputs are deasserted within two clocks from any state.
module low_power_state_and_smm_entry
  import lp_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire logic             stop_clock_request_n_in,
  input  wire logic             sleep_request_n_in,
  input  wire logic             sys_mgmt_interrupt_n_in,
  input  wire logic [IRQ_W-1:0] irq_in,
  input  wire logic             snoop_req_in,
  input  wire logic             smm_exit_in,
  input  wire logic [31:0]      exec_state_in,
  output logic [NUM_UNITS-1:0]  unit_clk_en_out,
  output logic                  ack_valid_out,
  output logic [1:0]            ack_code_out,
  output logic                  snoop_resp_out,
  output logic [IRQ_W-1:0]      irq_service_out,
  output logic                  smm_handler_start_out,
  output logic [31:0]           saved_state_out,
  output logic [1:0]            state_out
);

  logic stop_clock_request_n_s;
  logic slp_s;
  logic smi_s;
  logic [IRQ_W-1:0] irq_s;

  // async pins pass two flops; the bus clock itself is never gated
  sync2 u_sync_stp (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(stop_clock_request_n_in),
                    .q_out(stop_clock_request_n_s));
  sync2 u_sync_slp (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(sleep_request_n_in),
                    .q_out(slp_s));
  sync2 u_sync_smi (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(sys_mgmt_interrupt_n_in),
                    .q_out(smi_s));

  genvar gi;
  generate
    for (gi = 0; gi < IRQ_W; gi++)
    begin : g_irq_sync
      logic irq_n;
      sync2 u_sync_irq (.clk_in(clk_in), .rstn_in(rstn_in), .d_in(~irq_in[gi]),
                        .q_out(irq_n));
      assign irq_s[gi] = ~irq_n;
    end
  endgenerate

  pwr_state_t       state_r, state_nxt;
  logic [2:0]       clk_en_r, clk_en_nxt;
  logic             ack_v_r, ack_v_nxt;
  logic [1:0]       ack_c_r, ack_c_nxt;
  logic             snoop_r, snoop_nxt;
  logic [IRQ_W-1:0] pend_r, pend_nxt;
  logic [IRQ_W-1:0] svc_r, svc_nxt;
  logic             smi_ack_done_r, smi_ack_done_nxt;
  logic             hstart_r, hstart_nxt;
  logic [31:0]      saved_r, saved_nxt;

  always_comb
  begin
    state_nxt        = state_r;
    clk_en_nxt       = clk_en_r;
    ack_v_nxt        = 1'b0;
    ack_c_nxt        = ACK_NONE;
    snoop_nxt        = 1'b0;
    pend_nxt         = pend_r;
    svc_nxt          = IRQ_NONE;
    smi_ack_done_nxt = smi_ack_done_r;
    hstart_nxt       = 1'b0;
    saved_nxt        = saved_r;
    case (state_r)
      ST_RUN:
      begin
        snoop_nxt  = snoop_req_in;
        clk_en_nxt = CLK_ALL;
        svc_nxt    = irq_s;
        if (!smi_s)
        begin
          state_nxt        = ST_SMM;
          saved_nxt        = exec_state_in;
          smi_ack_done_nxt = 1'b0;
        end
        else if (!stop_clock_request_n_s)
        begin
          state_nxt  = ST_GRANT;
          clk_en_nxt = CLK_KEEP;
          ack_v_nxt  = 1'b1;
          ack_c_nxt  = ACK_GRANT;
        end
      end
      ST_GRANT:
      begin
        snoop_nxt = snoop_req_in;
        pend_nxt  = pend_r | irq_s;
        if (stop_clock_request_n_s)
        begin
          state_nxt  = ST_RUN;
          clk_en_nxt = CLK_ALL;
          svc_nxt    = pend_r | irq_s;
          pend_nxt   = IRQ_NONE;
        end
        else if (!slp_s)
        begin
          state_nxt  = ST_SLEEP;
          clk_en_nxt = CLK_NONE;
        end
        else
          clk_en_nxt = CLK_KEEP;
      end
      ST_SLEEP:
      begin
        // snoops, interrupts and the management pin are not looked at here
        clk_en_nxt = CLK_NONE;
        if (slp_s)
        begin
          state_nxt  = ST_GRANT;
          clk_en_nxt = CLK_KEEP;
        end
      end
      ST_SMM:
      begin
        snoop_nxt  = snoop_req_in;
        clk_en_nxt = CLK_ALL;
        if (!smi_ack_done_r)
        begin
          ack_v_nxt        = 1'b1;
          ack_c_nxt        = ACK_SMI;
          smi_ack_done_nxt = 1'b1;
        end
        else if (smi_ack_done_r && ack_v_r)
          hstart_nxt = 1'b1;
        else if (smm_exit_in)
          state_nxt = ST_RUN;
      end
      default:
      begin
        state_nxt  = ST_RUN;
        clk_en_nxt = CLK_ALL;
      end
    endcase
  end

  // synchronous reset clears every bus output on the next edge
  always_ff @(posedge clk_in)
  begin
    if (!rstn_in)
    begin
      state_r        <= ST_RUN;
      clk_en_r       <= CLK_ALL;
      ack_v_r        <= 1'b0;
      ack_c_r        <= ACK_NONE;
      snoop_r        <= 1'b0;
      pend_r         <= IRQ_NONE;
      svc_r          <= IRQ_NONE;
      smi_ack_done_r <= 1'b0;
      hstart_r       <= 1'b0;
      saved_r        <= 32'h0000_0000;
    end
    else
    begin
      state_r        <= state_nxt;
      clk_en_r       <= clk_en_nxt;
      ack_v_r        <= ack_v_nxt;
      ack_c_r        <= ack_c_nxt;
      snoop_r        <= snoop_nxt;
      pend_r         <= pend_nxt;
      svc_r          <= svc_nxt;
      smi_ack_done_r <= smi_ack_done_nxt;
      hstart_r       <= hstart_nxt;
      saved_r        <= saved_nxt;
    end
  end

  assign unit_clk_en_out       = clk_en_r;
  assign ack_valid_out         = ack_v_r;
  assign ack_code_out          = ack_c_r;
  assign snoop_resp_out        = snoop_r;
  assign irq_service_out       = svc_r;
  assign smm_handler_start_out = hstart_r;
  assign saved_state_out       = saved_r;
  assign state_out             = state_r;

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_grant_entry;
    (state_r == ST_RUN && !stop_clock_request_n_s && smi_s) |=> (state_r == ST_GRANT);
  endproperty
  a_grant_entry: assert property (p_grant_entry) else $error("no stop-grant entry");

  property p_grant_ack;
    (state_r == ST_GRANT && $past(state_r) == ST_RUN)
      |-> (ack_valid_out && ack_code_out == ACK_GRANT);
  endproperty
  a_grant_ack: assert property (p_grant_ack) else $error("missing stop-grant ack");

  property p_grant_clocks;
    (state_r == ST_GRANT) |-> (clk_en_r == CLK_KEEP);
  endproperty
  a_grant_clocks: assert property (p_grant_clocks) else $error("wrong grant clocks");

  property p_sleep_clocks;
    // a snoop taken in the last grant cycle is still answered in the first sleep cycle
    (state_r == ST_SLEEP)
      |-> (clk_en_r == CLK_NONE && ($past(state_r) != ST_SLEEP || !snoop_r));
  endproperty
  a_sleep_clocks: assert property (p_sleep_clocks) else $error("clocks on in sleep");

  property p_sleep_stay;
    (state_r == ST_SLEEP && !slp_s) |=> (state_r == ST_SLEEP && irq_service_out == IRQ_NONE);
  endproperty
  a_sleep_stay: assert property (p_sleep_stay) else $error("left sleep early");

  property p_sleep_exit;
    (state_r == ST_SLEEP && slp_s) |=> (state_r == ST_GRANT && clk_en_r == CLK_KEEP);
  endproperty
  a_sleep_exit: assert property (p_sleep_exit) else $error("bad sleep exit");

  property p_smi_ack;
    (state_r == ST_RUN && !smi_s) |=> ##1 (ack_valid_out && ack_code_out == ACK_SMI)
      ##1 smm_handler_start_out;
  endproperty
  a_smi_ack: assert property (p_smi_ack) else $error("smi ack sequence wrong");

  property p_no_sleep_run;
    (state_r == ST_RUN && stop_clock_request_n_s && smi_s && !slp_s) |=> (state_r == ST_RUN);
  endproperty
  a_no_sleep_run: assert property (p_no_sleep_run)
    else $error("sleep acted outside grant");

  property p_reset_quiet;
    @(posedge clk_in) (!rstn_in) |=> (!ack_valid_out && !snoop_resp_out);
  endproperty
  a_reset_quiet: assert property (disable iff (1'b0) p_reset_quiet)
    else $error("bus outputs active after reset");

  c_sleep: cover property (state_r == ST_GRANT ##1 state_r == ST_SLEEP);
  c_wake:  cover property (state_r == ST_GRANT ##1 state_r == ST_RUN);
  c_smm:   cover property (smm_handler_start_out);

endmodule // low_power_state_and_smm_entry

// File: test/lp_sys_model.sv
module lp_sys_model
  import lp_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             slow_in,
  input  wire logic             stop_in,
  input  wire logic             sleep_in,
  input  wire logic             smi_in,
  input  wire logic [IRQ_W-1:0] irq_in,
  output logic                  stop_n_out,
  output logic                  sleep_n_out,
  output logic                  smi_n_out,
  output logic [IRQ_W-1:0]      irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [IRQ_W+2:0] late_r = '0;
  // slow mode moves the pins mid-cycle, on the falling edge, half a cycle from the sampling edge
  always @(negedge clk_in)
    late_r <= {irq_in, smi_in, sleep_in, stop_in};
  // request lines are active low, interrupt levels active high
  assign {irq_out, smi_n_out, sleep_n_out, stop_n_out} =
    (slow_in ? late_r : {irq_in, smi_in, sleep_in, stop_in}) ^ {{IRQ_W{1'b0}}, 3'h7};
endmodule // lp_sys_model

// File: test/testbench.sv
module testbench
  import lp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic             clk_in = 0, rstn_in = 0, slow = 0;
  logic             stop_req = 0, sleep_req = 0, smi_req = 0;
  logic             snoop_req = 0, smm_exit = 0;
  logic [IRQ_W-1:0] irq_req = '0, pend;
  logic [31:0]      exec_state = '0;
  logic             stop_n, sleep_n, smi_n, ack_valid, snoop_resp, handler_start;
  logic [IRQ_W-1:0] irq_pins, irq_service;
  logic [2:0]       clk_en;
  logic [1:0]       ack_code, state;
  logic [31:0]      saved_state;
  int               bad_count = 0, n_checks = 0, hit;

  always #10 clk_in = ~clk_in;

  lp_sys_model u_sys (.clk_in(clk_in), .slow_in(slow), .stop_in(stop_req),
    .sleep_in(sleep_req), .smi_in(smi_req), .irq_in(irq_req), .stop_n_out(stop_n),
    .sleep_n_out(sleep_n), .smi_n_out(smi_n), .irq_out(irq_pins));

  low_power_state_and_smm_entry u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .stop_clock_request_n_in(stop_n), .sleep_request_n_in(sleep_n),
    .sys_mgmt_interrupt_n_in(smi_n), .irq_in(irq_pins), .snoop_req_in(snoop_req),
    .smm_exit_in(smm_exit), .exec_state_in(exec_state), .unit_clk_en_out(clk_en),
    .ack_valid_out(ack_valid), .ack_code_out(ack_code), .snoop_resp_out(snoop_resp),
    .irq_service_out(irq_service), .smm_handler_start_out(handler_start),
    .saved_state_out(saved_state), .state_out(state));

  function automatic logic [2:0] exp_clk(input pwr_state_t s);
    case (s)
      ST_GRANT: return CLK_KEEP;
      ST_SLEEP: return CLK_NONE;
      default:  return CLK_ALL;
    endcase
  endfunction

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // bounded wait: pin latency is synchronizer plus state edge
  task automatic wait_state(input pwr_state_t s);
    int i;
    i = 0;
    while (state !== s && i < 12)
    begin
      step(1);
      i++;
    end
    if (state !== s)
    begin
      bad_count++;
      $display("Error %0t timeout waiting for state %b", $time, s);
      give_verdict();
    end
  endtask

  task automatic snoop(input logic exp);
    @(posedge clk_in);
    snoop_req <= 1;
    @(posedge clk_in);
    snoop_req <= 0;
    #1;
    chk(snoop_resp, exp);
  endtask

  initial
  begin
    void'($urandom(76));
    step(3);
    rstn_in <= 1;
    chk(state, ST_RUN);
    for (int it = 0; it < 3; it++)
    begin
      slow <= it[0];
      pend = IRQ_W'($urandom) | 8'h01;
      sleep_req <= 1;
      step(6);
      chk(state, ST_RUN);
      sleep_req <= 0;
      stop_req <= 1;
      wait_state(ST_GRANT);
      chk({ack_valid, ack_code}, {1'b1, ACK_GRANT});
      chk(clk_en, exp_clk(ST_GRANT));
      step(1);
      chk(ack_valid, 0);
      snoop(1);
      irq_req <= pend;
      step(6);
      irq_req <= '0;
      step(4);
      sleep_req <= 1;
      wait_state(ST_SLEEP);
      chk(clk_en, exp_clk(ST_SLEEP));
      snoop(0);
      irq_req <= ~pend;
      smi_req <= 1;
      step(6);
      irq_req <= '0;
      smi_req <= 0;
      step(4);
      chk(state, ST_SLEEP);
      sleep_req <= 0;
      wait_state(ST_GRANT);
      chk(clk_en, exp_clk(ST_GRANT));
      stop_req <= 0;
      hit = 0;
      for (int i = 0; i < 10; i++)
      begin
        step(1);
        if (irq_service === pend)
          hit++;
      end
      chk(hit, 1);
      chk({state, clk_en}, {ST_RUN, exp_clk(ST_RUN)});
      exec_state <= $urandom;
      smi_req <= 1;
      wait_state(ST_SMM);
      chk(saved_state, exec_state);
      // the pin is a level: still low at the exit it would re-enter management mode
      smi_req <= 0;
      step(1);
      chk({ack_valid, ack_code}, {1'b1, ACK_SMI});
      step(1);
      chk({handler_start, ack_valid}, 2'h2);
      smm_exit <= 1;
      step(1);
      smm_exit <= 0;
      wait_state(ST_RUN);
      $display("test %0d done", it);
    end
    stop_req <= 1;
    wait_state(ST_GRANT);
    sleep_req <= 1;
    wait_state(ST_SLEEP);
    rstn_in <= 0;
    stop_req <= 0;
    sleep_req <= 0;
    step(2);
    chk({state, clk_en, ack_valid}, {ST_RUN, CLK_ALL, 1'b0});
    rstn_in <= 1;
    step(2);
    chk({state, clk_en, ack_valid, snoop_resp}, {ST_RUN, CLK_ALL, 2'b00});
    $display("test reset done");
    give_verdict();
  end
endmodule // testbench
